/* design/tdhp_consts.svh */
`ifndef TDHP_CONSTS_SVH
`define TDHP_CONSTS_SVH

// ****************************************************************
// Command byte fields
// ****************************************************************
`define TDHP_TYPE_HI      7
`define TDHP_TYPE_LO      5
`define TDHP_TYPE_SELECT  3'h0
`define TDHP_TYPE_POSN    3'h1
`define TDHP_TYPE_WRITE   3'h2
`define TDHP_TYPE_WFM     3'h3
`define TDHP_TYPE_READ    3'h4
`define TDHP_TYPE_RFM     3'h5
`define TDHP_TYPE_STATUS  3'h6
`define TDHP_TYPE_RSVD    3'h7
`define TDHP_POSN_LO_HI   4
`define TDHP_POSN_BOT     5'h01
`define TDHP_POSN_ERASE   5'h02
`define TDHP_POSN_RETEN   5'h04

// ****************************************************************
// Status read and reset values
// ****************************************************************
`define TDHP_STAT_LAST    3'h5
`define TDHP_STAT_FIRST   3'h0
`define TDHP_PIN_NEGATED  1'h1
`define TDHP_PIN_ASSERTED 1'h0
`define TDHP_BUS_IDLE     8'hff
`define TDHP_BYTE_ZERO    8'h00

`endif

/* design/tdhp_pkg.sv */
package tdhp_pkg;

  typedef enum logic [2:0] {
    tdhp_idle,
    tdhp_rel,
    tdhp_busy,
    tdhp_write,
    tdhp_read,
    tdhp_stat_drv,
    tdhp_stat_rdy,
    tdhp_stat_rel
  } tdhp_state_t;

  typedef enum logic [1:0] {
    tdhp_rd_idle,
    tdhp_rd_drive,
    tdhp_rd_ack,
    tdhp_rd_rel
  } tdhp_rd_ph_t;

  typedef struct packed {
    logic prev;
  } tdhp_edge_t;

  typedef struct packed {
    tdhp_state_t state;
    tdhp_rd_ph_t rd_ph;
    logic [7:0]  cmd;
    logic        accept;
    logic        reject;
    logic [2:0]  stat_idx;
    logic        ready_b;
    logic        exc_b;
    logic        dir_b;
    logic        ack_b;
    logic [7:0]  bus_lvl;
    logic        bus_oe;
    logic        cmd_valid;
    logic [7:0]  wr_data;
    logic        wr_valid;
    logic        rd_take;
    logic        stat_done;
    logic        online_drop;
    logic        reset_seq;
  } tdhp_port_t;

endpackage

/* design/tdhp_strobe_edge.sv */
`timescale 1ns/1ps
module tdhp_strobe_edge (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic level_b_in,
  output logic      asserted_out,
  output logic      rise_out,
  output logic      fall_out
);

  tdhp_pkg::tdhp_edge_t st;
  tdhp_pkg::tdhp_edge_t next_st;

  always_comb begin
    next_st      = st;
    next_st.prev = ~level_b_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st.prev <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  // Active-low pin turned into a level and its two edges
  assign asserted_out = ~level_b_in;
  assign rise_out     = ~level_b_in & ~st.prev;
  assign fall_out     = level_b_in & st.prev;

endmodule

/* design/tdhp_cmd_decode.sv */
`timescale 1ns/1ps
`include "tdhp_consts.svh"
module tdhp_cmd_decode (
  input  wire logic [7:0] cmd_in,
  output logic            is_select_out,
  output logic            is_posn_out,
  output logic            is_write_out,
  output logic            is_wfm_out,
  output logic            is_read_out,
  output logic            is_rfm_out,
  output logic            is_status_out,
  output logic            is_bad_out,
  output logic            needs_online_out
);

  logic [2:0] kind;
  logic [4:0] low;
  logic       posn_ok;

  assign kind = cmd_in[`TDHP_TYPE_HI:`TDHP_TYPE_LO];
  assign low  = cmd_in[`TDHP_POSN_LO_HI:0];
  // Rewind, erase and retension told apart by the low bits
  assign posn_ok = (low == `TDHP_POSN_BOT) || (low == `TDHP_POSN_ERASE)
                   || (low == `TDHP_POSN_RETEN);

  assign is_select_out    = (kind == `TDHP_TYPE_SELECT);
  assign is_posn_out      = (kind == `TDHP_TYPE_POSN) && posn_ok;
  assign is_write_out     = (kind == `TDHP_TYPE_WRITE);
  assign is_wfm_out       = (kind == `TDHP_TYPE_WFM);
  assign is_read_out      = (kind == `TDHP_TYPE_READ);
  assign is_rfm_out       = (kind == `TDHP_TYPE_RFM);
  assign is_status_out    = (kind == `TDHP_TYPE_STATUS);
  assign is_bad_out       = (kind == `TDHP_TYPE_RSVD)
                            || ((kind == `TDHP_TYPE_POSN) && !posn_ok);
  assign needs_online_out = is_write_out || is_wfm_out || is_read_out || is_rfm_out;

endmodule

/* design/tdhp_host_port.sv */
`timescale 1ns/1ps
`include "tdhp_consts.svh"
module tdhp_host_port (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] host_bus_b_in,
  output logic      [7:0] host_bus_b_out,
  output logic            host_bus_oe_out,
  input  wire logic       online_ctl_b_in,
  input  wire logic       request_b_in,
  input  wire logic       host_reset_b_in,
  input  wire logic       data_strobe_b_in,
  output logic            ack_b_out,
  output logic            ready_b_out,
  output logic            exception_flag_b_out,
  output logic            direction_b_out,
  input  wire logic       op_done_in,
  input  wire logic       wr_space_in,
  input  wire logic       rd_buf_ready_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       exc_cond_in,
  input  wire logic [7:0] stat_data_in,
  output logic      [2:0] stat_idx_out,
  output logic            cmd_valid_out,
  output logic      [7:0] cmd_byte_out,
  output logic            wr_valid_out,
  output logic      [7:0] wr_data_out,
  output logic            rd_take_out,
  output logic            stat_done_out,
  output logic            online_drop_out,
  output logic            reset_seq_out
);

  // ****************************************************************
  // Pin conditioning
  // ****************************************************************
  localparam tdhp_pkg::tdhp_port_t RESET_VAL = '{
    state: tdhp_pkg::tdhp_idle, rd_ph: tdhp_pkg::tdhp_rd_idle,
    cmd: `TDHP_BYTE_ZERO, accept: 1'h0, reject: 1'h0, stat_idx: `TDHP_STAT_FIRST,
    ready_b: `TDHP_PIN_ASSERTED, exc_b: `TDHP_PIN_NEGATED,
    dir_b: `TDHP_PIN_NEGATED, ack_b: `TDHP_PIN_NEGATED,
    bus_lvl: `TDHP_BUS_IDLE, bus_oe: 1'h0, cmd_valid: 1'h0,
    wr_data: `TDHP_BYTE_ZERO, wr_valid: 1'h0, rd_take: 1'h0,
    stat_done: 1'h0, online_drop: 1'h0, reset_seq: 1'h0};

  tdhp_pkg::tdhp_port_t st;
  tdhp_pkg::tdhp_port_t next_st;

  logic [7:0] bus_data;
  logic       host_reset_on;
  logic       req_on;
  logic       req_rise;
  logic       strobe_on;
  logic       strobe_rise;
  logic       online_on;
  logic       online_fall;
  logic       excepting;
  logic       live_ok;
  logic       live_reject;
  logic       take_unready;
  logic       l_select;
  logic       l_posn;
  logic       l_write;
  logic       l_wfm;
  logic       l_read;
  logic       l_rfm;
  logic       l_status;
  logic       l_bad;
  logic       l_online;
  logic       c_select;
  logic       c_posn;
  logic       c_write;
  logic       c_wfm;
  logic       c_read;
  logic       c_rfm;
  logic       c_status;

  assign bus_data      = ~host_bus_b_in;
  assign host_reset_on = ~host_reset_b_in;
  assign excepting     = (st.exc_b == `TDHP_PIN_ASSERTED);

  tdhp_strobe_edge u_req_edge (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .level_b_in   (request_b_in),
    .asserted_out (req_on),
    .rise_out     (req_rise),
    .fall_out     ()
  );

  tdhp_strobe_edge u_strobe_edge (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .level_b_in   (data_strobe_b_in),
    .asserted_out (strobe_on),
    .rise_out     (strobe_rise),
    .fall_out     ()
  );

  tdhp_strobe_edge u_online_edge (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .level_b_in   (online_ctl_b_in),
    .asserted_out (online_on),
    .rise_out     (),
    .fall_out     (online_fall)
  );

  // Decode of the byte on the bus, for acceptance checks
  tdhp_cmd_decode u_live_dec (
    .cmd_in           (bus_data),
    .is_select_out    (l_select),
    .is_posn_out      (l_posn),
    .is_write_out     (l_write),
    .is_wfm_out       (l_wfm),
    .is_read_out      (l_read),
    .is_rfm_out       (l_rfm),
    .is_status_out    (l_status),
    .is_bad_out       (l_bad),
    .needs_online_out (l_online)
  );

  // Decode of the latched byte, for dispatch
  tdhp_cmd_decode u_cmd_dec (
    .cmd_in           (st.cmd),
    .is_select_out    (c_select),
    .is_posn_out      (c_posn),
    .is_write_out     (c_write),
    .is_wfm_out       (c_wfm),
    .is_read_out      (c_read),
    .is_rfm_out       (c_rfm),
    .is_status_out    (c_status),
    .is_bad_out       (),
    .needs_online_out ()
  );

  // Under exception only status read passes; otherwise online is checked
  assign live_ok      = excepting ? l_status
                                  : (!l_bad && !(l_online && !online_on));
  assign live_reject  = !excepting && (l_bad || (l_online && !online_on));
  assign take_unready = req_rise && excepting && l_status;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_st             = st;
    next_st.cmd_valid   = 1'h0;
    next_st.wr_valid    = 1'h0;
    next_st.rd_take     = 1'h0;
    next_st.stat_done   = 1'h0;
    next_st.online_drop = 1'h0;
    next_st.reset_seq   = 1'h0;
    next_st.exc_b       = ~(exc_cond_in | st.reject);
    case (st.state)
      tdhp_pkg::tdhp_idle: begin
        if (req_rise) begin
          next_st.cmd     = bus_data;
          next_st.accept  = live_ok;
          next_st.reject  = st.reject | live_reject;
          next_st.ready_b = `TDHP_PIN_NEGATED;
          next_st.state   = tdhp_pkg::tdhp_rel;
        end
      end
      tdhp_pkg::tdhp_rel: begin
        if (!req_on) begin
          next_st.cmd_valid = st.accept;
          next_st.state     = tdhp_pkg::tdhp_idle;
          next_st.ready_b   = `TDHP_PIN_ASSERTED;
          if (st.accept) begin
            if (c_posn || c_wfm || c_rfm) begin
              next_st.state   = tdhp_pkg::tdhp_busy;
              next_st.ready_b = `TDHP_PIN_NEGATED;
            end else if (c_write) begin
              next_st.state   = tdhp_pkg::tdhp_write;
              next_st.ready_b = ~wr_space_in;
            end else if (c_read) begin
              next_st.state   = tdhp_pkg::tdhp_read;
              next_st.rd_ph   = tdhp_pkg::tdhp_rd_idle;
              next_st.ready_b = ~rd_buf_ready_in;
            end else if (c_status) begin
              next_st.state   = tdhp_pkg::tdhp_stat_drv;
              next_st.ready_b = `TDHP_PIN_NEGATED;
            end else if (!c_select) begin
              next_st.state   = tdhp_pkg::tdhp_idle;
            end
          end
        end
      end
      tdhp_pkg::tdhp_busy: begin
        if (op_done_in) begin
          next_st.state   = tdhp_pkg::tdhp_idle;
          next_st.ready_b = `TDHP_PIN_ASSERTED;
        end else if (take_unready) begin
          next_st.cmd    = bus_data;
          next_st.accept = 1'h1;
          next_st.state  = tdhp_pkg::tdhp_rel;
        end
      end
      tdhp_pkg::tdhp_write: begin
        next_st.ready_b = ~wr_space_in;
        if (strobe_rise && st.ack_b) begin
          next_st.wr_data  = bus_data;
          next_st.wr_valid = 1'h1;
          next_st.ack_b    = `TDHP_PIN_ASSERTED;
        end else if (!strobe_on && !st.ack_b) begin
          next_st.ack_b    = `TDHP_PIN_NEGATED;
        end
        if (online_fall) begin
          next_st.online_drop = 1'h1;
          next_st.ack_b       = `TDHP_PIN_NEGATED;
          next_st.state       = tdhp_pkg::tdhp_idle;
          next_st.ready_b     = `TDHP_PIN_ASSERTED;
        end else if (req_rise && (!st.ready_b || take_unready)) begin
          next_st.cmd     = bus_data;
          next_st.accept  = live_ok;
          next_st.reject  = st.reject | live_reject;
          next_st.ready_b = `TDHP_PIN_NEGATED;
          next_st.state   = tdhp_pkg::tdhp_rel;
        end
      end
      tdhp_pkg::tdhp_read: begin
        next_st.ready_b = ~rd_buf_ready_in;
        case (st.rd_ph)
          tdhp_pkg::tdhp_rd_idle: begin
            if (rd_valid_in && !strobe_on) begin
              next_st.bus_lvl = ~rd_data_in;
              next_st.bus_oe  = 1'h1;
              next_st.dir_b   = `TDHP_PIN_ASSERTED;
              next_st.rd_ph   = tdhp_pkg::tdhp_rd_drive;
            end
          end
          tdhp_pkg::tdhp_rd_drive: begin
            next_st.ack_b = `TDHP_PIN_ASSERTED;
            next_st.rd_ph = tdhp_pkg::tdhp_rd_ack;
          end
          tdhp_pkg::tdhp_rd_ack: begin
            if (strobe_rise) begin
              next_st.rd_take = 1'h1;
              next_st.ack_b   = `TDHP_PIN_NEGATED;
              next_st.rd_ph   = tdhp_pkg::tdhp_rd_rel;
            end
          end
          tdhp_pkg::tdhp_rd_rel: begin
            if (!strobe_on) begin
              next_st.bus_oe = 1'h0;
              next_st.dir_b  = `TDHP_PIN_NEGATED;
              next_st.rd_ph  = tdhp_pkg::tdhp_rd_idle;
            end
          end
          default: begin
            next_st.rd_ph = tdhp_pkg::tdhp_rd_idle;
          end
        endcase
        // Host may only drive a command while the device has released the bus
        if (online_fall) begin
          next_st            = RESET_VAL;
          next_st.exc_b      = ~(exc_cond_in | st.reject);
          next_st.reject     = st.reject;
          next_st.online_drop = 1'h1;
        end else if (req_rise && st.rd_ph == tdhp_pkg::tdhp_rd_idle
                     && (!st.ready_b || take_unready)) begin
          next_st.bus_oe  = 1'h0;
          next_st.dir_b   = `TDHP_PIN_NEGATED;
          next_st.rd_ph   = tdhp_pkg::tdhp_rd_idle;
          next_st.cmd     = bus_data;
          next_st.accept  = live_ok;
          next_st.reject  = st.reject | live_reject;
          next_st.ready_b = `TDHP_PIN_NEGATED;
          next_st.state   = tdhp_pkg::tdhp_rel;
        end
      end
      tdhp_pkg::tdhp_stat_drv: begin
        next_st.bus_lvl = ~stat_data_in;
        next_st.bus_oe  = 1'h1;
        next_st.dir_b   = `TDHP_PIN_ASSERTED;
        next_st.state   = tdhp_pkg::tdhp_stat_rdy;
      end
      tdhp_pkg::tdhp_stat_rdy: begin
        next_st.ready_b = `TDHP_PIN_ASSERTED;
        if (req_rise) begin
          next_st.ready_b = `TDHP_PIN_NEGATED;
          next_st.state   = tdhp_pkg::tdhp_stat_rel;
        end
      end
      tdhp_pkg::tdhp_stat_rel: begin
        if (!req_on) begin
          if (st.stat_idx == `TDHP_STAT_LAST) begin
            next_st.stat_done = 1'h1;
            next_st.reject    = 1'h0;
            next_st.stat_idx  = `TDHP_STAT_FIRST;
            next_st.bus_oe    = 1'h0;
            next_st.dir_b     = `TDHP_PIN_NEGATED;
            next_st.ready_b   = `TDHP_PIN_ASSERTED;
            next_st.state     = tdhp_pkg::tdhp_idle;
          end else begin
            next_st.stat_idx = st.stat_idx + 3'h1;
            next_st.state    = tdhp_pkg::tdhp_stat_drv;
          end
        end
      end
      default: begin
        next_st = RESET_VAL;
      end
    endcase
    if (host_reset_on) begin
      next_st           = RESET_VAL;
      next_st.reset_seq = 1'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st <= RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign host_bus_b_out       = st.bus_lvl;
  assign host_bus_oe_out      = st.bus_oe;
  assign ack_b_out            = st.ack_b;
  assign ready_b_out          = st.ready_b;
  assign exception_flag_b_out = st.exc_b;
  assign direction_b_out      = st.dir_b;
  assign stat_idx_out         = st.stat_idx;
  assign cmd_valid_out        = st.cmd_valid;
  assign cmd_byte_out         = st.cmd;
  assign wr_valid_out         = st.wr_valid;
  assign wr_data_out          = st.wr_data;
  assign rd_take_out          = st.rd_take;
  assign stat_done_out        = st.stat_done;
  assign online_drop_out      = st.online_drop;
  assign reset_seq_out        = st.reset_seq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_idle_req;
    st.state == tdhp_pkg::tdhp_idle && req_rise && !host_reset_on;
  endsequence

  sequence s_offline_cmd;
    s_idle_req ##0 (!excepting && l_online && !online_on);
  endsequence

  sequence s_stat_drive;
    st.state == tdhp_pkg::tdhp_stat_drv && !host_reset_on;
  endsequence

  sequence s_write_strobe;
    st.state == tdhp_pkg::tdhp_write && strobe_rise && st.ack_b
      && !online_fall && !host_reset_on;
  endsequence

  a_ready_drops: assert property (s_idle_req |=> ready_b_out)
    else $error("ready stayed asserted after a request");
  a_offline_exc: assert property (
    s_offline_cmd ##1 !host_reset_on |=> !exception_flag_b_out)
    else $error("offline data command did not raise exception");
  a_stat_ready: assert property (
    s_stat_drive |=> (!direction_b_out && host_bus_oe_out) ##1 !ready_b_out)
    else $error("status byte not presented with ready");
  a_busy_done: assert property (
    st.state == tdhp_pkg::tdhp_busy && op_done_in && !host_reset_on |=> !ready_b_out)
    else $error("ready missing after operation done");
  a_write_ack: assert property (
    s_write_strobe |=> !ack_b_out && wr_valid_out && wr_data_out == $past(bus_data))
    else $error("write byte not acknowledged");
  a_ack_hold: assert property (
    st.state == tdhp_pkg::tdhp_write && !ack_b_out && strobe_on && !online_fall
      && !host_reset_on |=> !ack_b_out)
    else $error("acknowledge dropped while strobe held");
  a_exc_follow: assert property (exc_cond_in && !host_reset_on |=> !exception_flag_b_out)
    else $error("exception not shown for internal condition");
  a_dir_drive: assert property (host_bus_oe_out == !direction_b_out)
    else $error("bus drive disagrees with direction");
  a_host_reset: assert property (
    host_reset_on |=> reset_seq_out && !ready_b_out && direction_b_out)
    else $error("host reset did not restart the port");
  a_select_idle: assert property (
    cmd_valid_out && cmd_byte_out[7:5] == `TDHP_TYPE_SELECT |-> st.state == tdhp_pkg::tdhp_idle)
    else $error("select command left the port busy");

endmodule

/* tb/tdhp_host_model.sv */
`timescale 1ns/1ps
module tdhp_host_model (
  input  wire logic [7:0] dev_bus_b_in,
  input  wire logic       dev_oe_in,
  input  wire logic       direction_b_in,
  input  wire logic [7:0] host_byte_in,
  output logic      [7:0] wire_b_out
);
  // ****************************************************************
  // Shared bus level
  // ****************************************************************
  // Host drives only while direction is negated; terminators pull the idle bus high
  always_comb begin
    if (dev_oe_in) begin
      wire_b_out = dev_bus_b_in;
    end else if (direction_b_in) begin
      wire_b_out = ~host_byte_in;
    end else begin
      wire_b_out = 8'hff;
    end
  end
endmodule

/* tb/tdhp_host_port_tb.sv */
`timescale 1ns/1ps
module tdhp_host_port_tb;
  logic clk_in = 1'h0, rst_b_in = 1'h0, onl_b = 1'h1, req_b = 1'h1, hrst_b = 1'h1, stb_b = 1'h1;
  logic op_done = 1'h0, wr_space = 1'h0, rd_rdy = 1'h0, rd_vld = 1'h0, exc_cond = 1'h0;
  logic [7:0] hbyte = 8'h00, rd_data = 8'h00, wire_b, bus_b, wr_data, cmd_byte, last_wr, last_cmd;
  logic [15:0] lfsr = 16'hc0cb;
  logic [2:0] sidx;
  logic oe, ack_b, rdy_b, exc_b, dir_b, cmd_v, wr_v, rd_take, st_done, on_drop, rst_seq;
  int err_count = 0, num_checks = 0, n_cmd = 0, n_std = 0, n_drop = 0, n_rst = 0, n_take = 0;
  int i;
  logic [7:0] d;

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  tdhp_host_model u_host (.dev_bus_b_in(bus_b), .dev_oe_in(oe), .direction_b_in(dir_b),
    .host_byte_in(hbyte), .wire_b_out(wire_b));

  tdhp_host_port u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .host_bus_b_in(wire_b),
    .host_bus_b_out(bus_b), .host_bus_oe_out(oe), .online_ctl_b_in(onl_b),
    .request_b_in(req_b), .host_reset_b_in(hrst_b), .data_strobe_b_in(stb_b),
    .ack_b_out(ack_b), .ready_b_out(rdy_b), .exception_flag_b_out(exc_b),
    .direction_b_out(dir_b), .op_done_in(op_done), .wr_space_in(wr_space),
    .rd_buf_ready_in(rd_rdy), .rd_valid_in(rd_vld), .rd_data_in(rd_data),
    .exc_cond_in(exc_cond), .stat_data_in({5'h15, sidx}), .stat_idx_out(sidx),
    .cmd_valid_out(cmd_v), .cmd_byte_out(cmd_byte), .wr_valid_out(wr_v),
    .wr_data_out(wr_data), .rd_take_out(rd_take), .stat_done_out(st_done),
    .online_drop_out(on_drop), .reset_seq_out(rst_seq));

  // ****************************************************************
  // Pulse monitors
  // ****************************************************************
  // Sampled mid-cycle, where the registered outputs have settled
  always @(negedge clk_in) begin
    if (cmd_v === 1'h1) begin
      n_cmd++;
      last_cmd = cmd_byte;
    end
    if (wr_v === 1'h1) last_wr = wr_data;
    if (st_done === 1'h1) n_std++;
    if (on_drop === 1'h1) n_drop++;
    if (rst_seq === 1'h1) n_rst++;
    if (rd_take === 1'h1) n_take++;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_lvl(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v) begin
      @(posedge clk_in);
      #1;
      k++;
      if (k > 300) begin
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        print_verdict();
      end
    end
  endtask

  task automatic send_cmd(input logic [7:0] b);
    @(posedge clk_in);
    hbyte <= b;
    if (exc_b !== 1'h0) wait_lvl(rdy_b, 1'h0);
    @(posedge clk_in);
    req_b <= 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
    wait_lvl(rdy_b, 1'h1);
    @(posedge clk_in);
    req_b <= 1'h1;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic status_read;
    int k;
    int s0;
    s0 = n_std;
    send_cmd(8'hc0);
    for (k = 0; k < 6; k++) begin
      wait_lvl(rdy_b, 1'h0);
      chk_bit(dir_b, 1'h0);
      chk_byte(wire_b, ~{5'h15, k[2:0]});
      @(posedge clk_in);
      req_b <= 1'h0;
      wait_lvl(rdy_b, 1'h1);
      @(posedge clk_in);
      req_b <= 1'h1;
    end
    wait_lvl(dir_b, 1'h1);
    repeat (2) @(posedge clk_in);
    #1;
    chk_bit(n_std == s0 + 1, 1'h1);
    chk_bit(exc_b, 1'h1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'h1;
    @(posedge clk_in);
    #1;
    chk_byte({3'h0, rdy_b, exc_b, dir_b, ack_b, oe}, 8'h0e);
    for (i = 0; i < 8; i++) begin
      send_cmd({3'h0, i[2], 4'h1 << i[1:0]});
      chk_byte(last_cmd, {3'h0, i[2], 4'h1 << i[1:0]});
      chk_bit(rdy_b, 1'h0);
    end
    for (i = 0; i < 3; i++) begin
      send_cmd(8'h20 | (8'h01 << i));
      chk_byte(last_cmd, 8'h20 | (8'h01 << i));
      chk_bit(rdy_b, 1'h1);
      @(posedge clk_in);
      op_done <= 1'h1;
      @(posedge clk_in);
      op_done <= 1'h0;
      wait_lvl(rdy_b, 1'h0);
    end
    send_cmd(8'h40);
    wait_lvl(exc_b, 1'h0);
    i = n_cmd;
    send_cmd(8'h01);
    chk_bit(n_cmd == i, 1'h1);
    status_read();
    send_cmd(8'he0);
    wait_lvl(exc_b, 1'h0);
    status_read();
    exc_cond <= 1'h1;
    wait_lvl(exc_b, 1'h0);
    exc_cond <= 1'h0;
    status_read();
    onl_b <= 1'h0;
    wr_space <= 1'h1;
    send_cmd(8'h40);
    wait_lvl(rdy_b, 1'h0);
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      d = lfsr[7:0];
      hbyte <= d;
      @(posedge clk_in);
      stb_b <= 1'h0;
      wait_lvl(ack_b, 1'h0);
      repeat (2) @(posedge clk_in);
      #1;
      chk_bit(ack_b, 1'h0);
      chk_byte(last_wr, d);
      @(posedge clk_in);
      stb_b <= 1'h1;
      wait_lvl(ack_b, 1'h1);
    end
    wr_space <= 1'h0;
    wait_lvl(rdy_b, 1'h1);
    onl_b <= 1'h1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_bit(n_drop == 1, 1'h1);
    onl_b <= 1'h0;
    for (i = 0; i < 2; i++) begin
      send_cmd(i[0] ? 8'ha0 : 8'h60);
      chk_bit(rdy_b, 1'h1);
      op_done <= 1'h1;
      @(posedge clk_in);
      op_done <= 1'h0;
      wait_lvl(rdy_b, 1'h0);
    end
    rd_rdy <= 1'h1;
    send_cmd(8'h80);
    wait_lvl(rdy_b, 1'h0);
    lfsr = lfsr_next(lfsr);
    d = lfsr[7:0];
    rd_data <= d;
    rd_vld <= 1'h1;
    wait_lvl(ack_b, 1'h0);
    chk_byte(wire_b, ~d);
    @(posedge clk_in);
    stb_b <= 1'h0;
    wait_lvl(ack_b, 1'h1);
    rd_vld <= 1'h0;
    stb_b <= 1'h1;
    wait_lvl(dir_b, 1'h1);
    chk_bit(n_take == 1, 1'h1);
    onl_b <= 1'h1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_bit(n_drop == 2 && rdy_b === 1'h0, 1'h1);
    hrst_b <= 1'h0;
    repeat (3) @(posedge clk_in);
    hrst_b <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    chk_bit(n_rst == 3 && rdy_b === 1'h0, 1'h1);
    print_verdict();
  end
endmodule
